// *** adc_ctrl_pkg.sv ***
package adc_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] STATUS_CTRL_OFS = 4'h0;
  localparam logic [3:0] RESULT_OFS = 4'h4;
  localparam logic [3:0] CLOCK_CFG_OFS = 4'h8;

  // Status/control field positions
  localparam int COMPLETE_BIT = 7;
  localparam int IRQ_EN_BIT = 6;
  localparam int CONT_BIT = 5;
  localparam int CHAN_LSB = 0;
  localparam int CHAN_W = 5;

  // Clock configuration field positions
  localparam int PRESCALE_LSB = 5;
  localparam int PRESCALE_W = 3;
  localparam int SOURCE_BIT = 4;

  // Values after reset
  localparam logic [4:0] CHAN_RESET = 5'h1f;
  localparam logic [2:0] PRESCALE_RESET = 3'h0;
  localparam logic SOURCE_RESET = 1'b0;

  // Channel codes of note
  localparam logic [4:0] CHAN_LAST_PIN = 5'h0e;
  localparam logic [4:0] CHAN_REF_HIGH = 5'h1d;
  localparam logic [4:0] CHAN_REF_LOW = 5'h1e;
  localparam logic [4:0] CHAN_POWER_OFF = 5'h1f;
  localparam int PIN_CHANNELS = 15;

  // Conversion timing in converter clocks
  localparam logic [4:0] SAMPLE_CLKS = 5'h08;
  localparam logic [4:0] CONV_CLKS = 5'h10;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register selector
  typedef enum logic [1:0] {
    SEL_STATUS = 2'h0,
    SEL_RESULT = 2'h1,
    SEL_CLOCK = 2'h2,
    SEL_NONE = 2'h3
  } reg_sel_t;

  // Converter sequencer, Gray along idle -> run
  typedef enum logic [1:0] {
    CONV_IDLE = 2'h0,
    CONV_RUN = 2'h1
  } conv_state_t;

endpackage

// *** adc_control_registers.sv ***
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
module adc_control_registers (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [adc_ctrl_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [adc_ctrl_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic crystal_clock,
  input wire logic input_below_trial,
  output logic [adc_ctrl_pkg::PIN_CHANNELS-1:0] analog_channel_en,
  output logic reference_high_sel,
  output logic reference_low_sel,
  output logic converter_power_down,
  output logic sample_enable,
  output logic [7:0] sar_trial,
  output logic conv_irq
);
  import adc_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic reg_sel_t decode_addr(input logic [ADDR_W-1:0] addr);
    if (addr == STATUS_CTRL_OFS) begin
      decode_addr = SEL_STATUS;
    end else if (addr == RESULT_OFS) begin
      decode_addr = SEL_RESULT;
    end else if (addr == CLOCK_CFG_OFS) begin
      decode_addr = SEL_CLOCK;
    end else begin
      decode_addr = SEL_NONE;
    end
  endfunction

  // Prescale code to terminal count (ratio minus one)
  function automatic logic [3:0] div_last(input logic [2:0] code);
    if (code[2]) begin
      div_last = 4'hf;
    end else if (code == 3'h3) begin
      div_last = 4'h7;
    end else if (code == 3'h2) begin
      div_last = 4'h3;
    end else if (code == 3'h1) begin
      div_last = 4'h1;
    end else begin
      div_last = 4'h0;
    end
  endfunction

  logic aw_got_q, w_got_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic wstrb0_q;
  logic bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic wr_fire, rd_fire, stat_wr, clk_wr, res_rd;
  reg_sel_t wr_sel, rd_sel;

  logic complete_q, irq_en_q, cont_q, irq_q;
  logic [CHAN_W-1:0] chan_q;
  logic [PRESCALE_W-1:0] prescale_q;
  logic source_q;
  logic [7:0] result_q;

  logic xclk_q, src_tick, conv_clk_en;
  logic [3:0] div_q;

  conv_state_t state_q;
  logic [4:0] cnt_q;
  logic [7:0] sar_q, mask_q;
  logic done, start, new_irq_en;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_got_q;
  assign s_axi_wready = !w_got_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // Address and data held until both are in; one write at a time
  assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
  assign wr_sel = decode_addr(awaddr_q);
  assign rd_fire = s_axi_arvalid && !rvalid_q;
  assign rd_sel = decode_addr(s_axi_araddr);
  // A write with byte 0 disabled touches no register and starts nothing
  assign stat_wr = wr_fire && wstrb0_q && (wr_sel == SEL_STATUS);
  assign clk_wr = wr_fire && wstrb0_q && (wr_sel == SEL_CLOCK);
  assign res_rd = rd_fire && (rd_sel == SEL_RESULT);

  // Write address and data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb0_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && !aw_got_q) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_got_q <= 1'b0;
      end
      if (s_axi_wvalid && !w_got_q) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_got_q <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read data; writes to the result register are accepted and dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      if (rd_sel == SEL_STATUS) begin
        rdata_q[7:0] <= {complete_q, irq_en_q, cont_q, chan_q};
      end else if (rd_sel == SEL_RESULT) begin
        rdata_q[7:0] <= result_q;
      end else if (rd_sel == SEL_CLOCK) begin
        rdata_q[7:0] <= {prescale_q, source_q, 4'h0};
      end else begin
        rresp_q <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  assign new_irq_en = wdata_q[IRQ_EN_BIT];

  // Mode and channel; power-down code out of reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en_q <= 1'b0;
      cont_q <= 1'b0;
      chan_q <= CHAN_RESET;
    end else if (stat_wr) begin
      irq_en_q <= new_irq_en;
      cont_q <= wdata_q[CONT_BIT];
      chan_q <= wdata_q[CHAN_LSB +: CHAN_W];
    end
  end

  // Clock setup; software keeps it still while converting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      source_q <= SOURCE_RESET;
      prescale_q <= PRESCALE_RESET;
    end else if (clk_wr) begin
      source_q <= wdata_q[SOURCE_BIT];
      prescale_q <= wdata_q[PRESCALE_LSB +: PRESCALE_W];
    end
  end

  // Complete bit: flag or plain bit depending on irq enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      complete_q <= 1'b0;
    end else if (stat_wr && new_irq_en) begin
      complete_q <= wdata_q[COMPLETE_BIT];
    end else if (done && !irq_en_q && !(stat_wr && new_irq_en)) begin
      complete_q <= 1'b1;
    end else if (!irq_en_q && (stat_wr || res_rd)) begin
      complete_q <= 1'b0;
    end
  end

  // Interrupt request, set wins over the clearing access unless a status write turns irq enable off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else if (done && irq_en_q && !(stat_wr && !new_irq_en)) begin
      irq_q <= 1'b1;
    end else if (stat_wr || res_rd) begin
      irq_q <= 1'b0;
    end
  end
  assign conv_irq = irq_q;

  // Result register, overwritten whether read or not
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_q <= 8'h00;
    end else if (done) begin
      result_q <= sar_q;
    end
  end

  // ----------------------------------------------------------------
  // Converter clock
  // ----------------------------------------------------------------
  // Crystal taken as a synchronous level; its rising edge is one tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xclk_q <= 1'b0;
    end else begin
      xclk_q <= crystal_clock;
    end
  end

  assign src_tick = source_q ? 1'b1 : (crystal_clock && !xclk_q);

  assign conv_clk_en = src_tick && (div_q >= div_last(prescale_q));

  // Divider count; restarts so a prescale change cannot strand it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 4'h0;
    end else if (conv_clk_en) begin
      div_q <= 4'h0;
    end else if (src_tick) begin
      div_q <= div_q + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  // every status write starts, unless powering down
  assign start = stat_wr && (wdata_q[CHAN_LSB +: CHAN_W] != CHAN_POWER_OFF);
  // completion is already in the bus domain
  assign done = (state_q == CONV_RUN) && conv_clk_en && (cnt_q == CONV_CLKS);

  // Partial first period plus 16 full ones gives 16 to 17 clocks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= CONV_IDLE;
      cnt_q <= 5'h00;
    end else if (start) begin
      // A write mid-conversion abandons it and begins afresh
      state_q <= CONV_RUN;
      cnt_q <= 5'h00;
    end else if (stat_wr) begin
      state_q <= CONV_IDLE;
    end else begin
      case (state_q)
        CONV_RUN: begin
          if (done) begin
            cnt_q <= 5'h00;
            state_q <= cont_q ? CONV_RUN : CONV_IDLE;
          end else if (conv_clk_en) begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
        default: begin
          state_q <= CONV_IDLE;
        end
      endcase
    end
  end

  // Successive approximation, MSB first after sampling
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sar_q <= 8'h00;
      mask_q <= 8'h00;
    end else if (state_q == CONV_RUN && conv_clk_en) begin
      if (cnt_q == SAMPLE_CLKS - 5'h01) begin
        sar_q <= 8'h80;
        mask_q <= 8'h80;
      end else if (cnt_q >= SAMPLE_CLKS && cnt_q < CONV_CLKS) begin
        sar_q <= (input_below_trial ? (sar_q & ~mask_q) : sar_q) | (mask_q >> 1);
        mask_q <= mask_q >> 1;
      end
    end
  end

  assign sample_enable = (state_q == CONV_RUN) && (cnt_q < SAMPLE_CLKS);
  assign sar_trial = sar_q;

  // ----------------------------------------------------------------
  // Analogue routing
  // ----------------------------------------------------------------
  // one-hot pin select, port B then port D
  for (genvar i = 0; i < PIN_CHANNELS; i++) begin : g_pin
    assign analog_channel_en[i] = (chan_q == CHAN_W'(i));
  end
  // internal references; other codes route nothing
  assign reference_high_sel = (chan_q == CHAN_REF_HIGH);
  assign reference_low_sel = (chan_q == CHAN_REF_LOW);
  assign converter_power_down = (chan_q == CHAN_POWER_OFF);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  irq_clear_a: assert property ((stat_wr || res_rd) && !done |=> !conv_irq)
    else $error("interrupt not dropped on access");
  irq_raise_a: assert property (done && irq_en_q && !stat_wr |=> conv_irq)
    else $error("interrupt not raised at completion");
  irq_quiet_a: assert property (!irq_en_q && !$past(irq_en_q) |-> !conv_irq)
    else $error("interrupt while disabled");
  flag_set_a: assert property (done && !irq_en_q && !stat_wr |=> complete_q)
    else $error("complete flag lost");
  flag_rw_a: assert property (stat_wr && new_irq_en |=> complete_q == $past(wdata_q[7]))
    else $error("complete bit not writable");
  result_load_a: assert property (done |=> result_q == $past(sar_q))
    else $error("result not loaded");
  one_shot_a: assert property (done && !cont_q && !stat_wr |=> state_q == CONV_IDLE)
    else $error("single conversion did not stop");
  chain_run_a: assert property (done && cont_q && !stat_wr |=> state_q == CONV_RUN)
    else $error("continuous conversion stopped");
  power_off_a: assert property (state_q == CONV_RUN |-> chan_q != CHAN_POWER_OFF)
    else $error("converting while powered down");
  div_one_a: assert property (source_q && prescale_q == 3'h0 |-> conv_clk_en)
    else $error("divide by one missed an enable");

endmodule

// *** adc_sar_model.sv ***
`timescale 1ns/10ps
// -------------------------------------------------
// Analogue mux and comparator seen by the sequencer
// -------------------------------------------------
module adc_sar_model (
  input wire logic aclk,
  input wire logic [14:0] channel_en,
  input wire logic ref_high_sel,
  input wire logic ref_low_sel,
  input wire logic power_down,
  input wire logic [7:0] trial,
  output logic below
);
  logic toggle_q = 1'h0;
  logic routed;
  logic [7:0] level;

  // Floating node flips every cycle so a stale level never looks valid
  always_ff @(posedge aclk) begin
    toggle_q <= ~toggle_q;
  end

  always_comb begin
    routed = 1'h1;
    level = 8'h00;
    for (int n = 0; n < 15; n++) begin
      if (channel_en[n]) level = {n[3:0], ~n[3:0]};
    end
    if (ref_high_sel) level = 8'hff;
    else if (ref_low_sel) level = 8'h00;
    else if (channel_en == 15'h0000) routed = 1'h0;
  end

  assign below = (power_down || !routed) ? toggle_q : (level < trial);
endmodule

// *** tb.sv ***
`timescale 1ns/10ps
module tb;
  import adc_ctrl_pkg::*;
  logic aclk, aresetn, crystal_clock, below, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, ref_hi, ref_lo, power_down;
  logic sample_en, conv_irq;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, data;
  logic [1:0] bresp, rresp, resp;
  logic [14:0] chan_en;
  logic [7:0] trial;
  logic [1:0] xtal_cnt_q = 2'h0;
  int num_errors = 0;
  int comparisons = 0;
  int n;
  // Rows: clock setup, channel, aclk per converter clock, expected result
  localparam logic [7:0] CFG [8] = '{8'h10, 8'h30, 8'h50, 8'h70, 8'h90, 8'hf0, 8'h00, 8'h20};
  localparam logic [4:0] CHAN [8] = '{5'h00, 5'h07, 5'h08, 5'h0e, 5'h1d, 5'h1e, 5'h03, 5'h0b};
  localparam int TK [8] = '{1, 2, 4, 8, 16, 16, 4, 8};
  localparam logic [7:0] EXP [8] = '{8'h0f, 8'h78, 8'h87, 8'he1, 8'hff, 8'h00, 8'h3c, 8'hb4};

  adc_control_registers adc_control_registers_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .crystal_clock(crystal_clock), .input_below_trial(below), .analog_channel_en(chan_en),
    .reference_high_sel(ref_hi), .reference_low_sel(ref_lo),
    .converter_power_down(power_down), .sample_enable(sample_en), .sar_trial(trial),
    .conv_irq(conv_irq));

  adc_sar_model adc_sar_model_inst (
    .aclk(aclk), .channel_en(chan_en), .ref_high_sel(ref_hi), .ref_low_sel(ref_lo),
    .power_down(power_down), .trial(trial), .below(below));

  initial begin
    aclk = 1'h0;
    forever #20 aclk = ~aclk;
  end

  // Crystal at a quarter of the bus rate, so one source tick per 4 aclk
  always @(posedge aclk) begin
    xtal_cnt_q <= xtal_cnt_q + 2'h1;
  end
  assign crystal_clock = xtal_cnt_q[1];

  // ------------------------------------------
  // Bus tasks, handshakes judged at the negedge
  // ------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    comparisons++;
    if (got !== want) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] st,
                    output logic [1:0] r);
    logic aw_t, w_t, b_t;
    b_t = 1'h0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    wstrb <= st;
    {awvalid, wvalid, bready} <= 3'h7;
    while (!b_t) begin
      @(negedge aclk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid && bready;
      r = bresp;
      @(posedge aclk);
      if (aw_t) awvalid <= 1'h0;
      if (w_t) wvalid <= 1'h0;
    end
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_t, r_t;
    r_t = 1'h0;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    while (!r_t) begin
      @(negedge aclk);
      ar_t = arvalid && arready;
      r_t = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar_t) arvalid <= 1'h0;
    end
    rready <= 1'h0;
  endtask

  // Bounded wait on the interrupt line; n saturates on a hang
  task automatic wait_irq();
    n = 0;
    @(negedge aclk);
    while (conv_irq !== 1'h1 && n < 600) begin
      n++;
      @(negedge aclk);
    end
    // A wait that runs out is a mismatch in its own right
    chk(n < 600, 1);
  endtask

  task automatic poll_done();
    n = 0;
    rd(STATUS_CTRL_OFS, data, resp);
    while (data[7] !== 1'h1 && n < 100) begin
      n++;
      rd(STATUS_CTRL_OFS, data, resp);
    end
  endtask

  task automatic tally_and_finish();
    if (num_errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    tally_and_finish();
  end

  // ---------
  // Scenarios
  // ---------
  initial begin
    aresetn = 1'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wstrb} = 12'h000;
    wdata = 32'h0000_0000;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    // Crystal here is slower than the target rate, so the bus clock is chosen
    wr(CLOCK_CFG_OFS, 8'h10, 4'hf, resp);
    wr(STATUS_CTRL_OFS, 8'h40, 4'hf, resp);
    wait_irq();
    rd(RESULT_OFS, data, resp);
    // Clock setup only rewritten while the converter is idle
    for (int i = 0; i < 8; i++) begin
      wr(CLOCK_CFG_OFS, CFG[i], 4'hf, resp);
      rd(CLOCK_CFG_OFS, data, resp);
      chk(data, {24'h00_0000, CFG[i]});
      wr(STATUS_CTRL_OFS, 8'h40 | CHAN[i], 4'hf, resp);
      wait_irq();
      chk(n >= 16 * TK[i] - 2 && n <= 18 * TK[i] + 4, 1);
      chk(chan_en, CHAN[i] < 5'h0f ? 15'h0001 << CHAN[i] : 15'h0000);
      chk({ref_hi, ref_lo}, {CHAN[i] == 5'h1d, CHAN[i] == 5'h1e});
      rd(RESULT_OFS, data, resp);
      chk(data, {24'h00_0000, EXP[i]});
      rd(STATUS_CTRL_OFS, data, resp);
      chk(data, {24'h00_0000, 8'h40 | CHAN[i]});
      chk(conv_irq, 0);
    end
    // Last row period is 8 aclk, so 300 cycles covers two conversions
    repeat (300) @(negedge aclk);
    chk(conv_irq, 0);
    wr(CLOCK_CFG_OFS, 8'h10, 4'hf, resp);
    wr(STATUS_CTRL_OFS, 8'h65, 4'hf, resp);
    repeat (2) begin
      wait_irq();
      chk(n <= 20, 1);
      chk(sample_en, 1);
      rd(RESULT_OFS, data, resp);
      chk(data, 32'h0000_005a);
    end
    wait_irq();
    wr(STATUS_CTRL_OFS, 8'h1f, 4'hf, resp);
    @(negedge aclk);
    chk(conv_irq, 0);
    chk(power_down, 1);
    repeat (60) @(negedge aclk);
    chk(conv_irq, 0);
    wr(STATUS_CTRL_OFS, 8'h03, 4'hf, resp);
    poll_done();
    chk(data, 32'h0000_0083);
    chk(conv_irq, 0);
    rd(RESULT_OFS, data, resp);
    chk(data, 32'h0000_003c);
    rd(STATUS_CTRL_OFS, data, resp);
    chk(data, 32'h0000_0003);
    wr(STATUS_CTRL_OFS, 8'h03, 4'hf, resp);
    poll_done();
    wr(STATUS_CTRL_OFS, 8'h1f, 4'hf, resp);
    rd(STATUS_CTRL_OFS, data, resp);
    chk(data, 32'h0000_001f);
    wr(STATUS_CTRL_OFS, 8'hdf, 4'hf, resp);
    rd(STATUS_CTRL_OFS, data, resp);
    chk(data, 32'h0000_00df);
    wr(STATUS_CTRL_OFS, 8'h1f, 4'hf, resp);
    wr(4'hc, 8'h55, 4'hf, resp);
    chk(resp, RESP_SLVERR);
    rd(4'hc, data, resp);
    chk(resp, RESP_SLVERR);
    chk(data, 32'h0000_0000);
    wr(RESULT_OFS, 8'haa, 4'hf, resp);
    chk(resp, RESP_OKAY);
    rd(RESULT_OFS, data, resp);
    chk(data, 32'h0000_003c);
    wr(STATUS_CTRL_OFS, 8'h43, 4'h0, resp);
    rd(STATUS_CTRL_OFS, data, resp);
    chk(data, 32'h0000_001f);
    chk(power_down, 1);
    // Second reset with an interrupt pending and continuous mode running
    wr(STATUS_CTRL_OFS, 8'h62, 4'hf, resp);
    wait_irq();
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(negedge aclk);
    chk(conv_irq, 0);
    chk(sample_en, 0);
    chk(power_down, 1);
    rd(STATUS_CTRL_OFS, data, resp);
    chk(data, 32'h0000_001f);
    rd(RESULT_OFS, data, resp);
    chk(data, 32'h0000_0000);
    rd(CLOCK_CFG_OFS, data, resp);
    chk(data, 32'h0000_0000);
    tally_and_finish();
  end
endmodule
